/* File: lcd_driver_i2c_command_port.sv */
// Serial command port of a segment display driver: receiver, queue and decoder
`timescale 1ns/1ps
`include "lcd_cmd_defines.svh"
module lcd_driver_i2c_command_port (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       address_lsb_select_pin_i,
    input  wire logic       hw_subaddr_bit_zero_i,
    input  wire logic       hw_subaddr_bit_one_i,
    input  wire logic       hw_subaddr_bit_two_i,
    output logic            power_saving_select_o,
    output logic            display_enable_o,
    output logic            bias_half_o,
    output logic [1:0]      drive_mode_o,
    output logic            input_bank_o,
    output logic            output_bank_o,
    output logic            alt_bank_blink_flag_o,
    output logic [1:0]      blink_rate_field_o,
    output logic [5:0]      data_ptr_o,
    output logic [2:0]      subaddr_cnt_o,
    output logic            wr_valid_o,
    output logic [5:0]      wr_addr_o,
    output logic [7:0]      wr_data_o,
    output logic            wr_bank_o
);
    localparam logic [4:0] LP_BUSY = 5'(`LP_PROC_CYCLES - 1);

    typedef struct packed {
        lcd_cmd_pkg::link_e     lstate;
        lcd_cmd_pkg::kind_e     kind;
        logic                   scl_prev;
        logic                   sda_prev;
        logic [3:0]             bit_cnt;
        logic [7:0]             shreg;
        logic                   pushed;
        logic                   fell;
        logic                   ack_hi;
        logic                   sda_oe;
        logic                   scl_oe;
        logic [4:0]             busy_cnt;
        lcd_cmd_pkg::mode_cfg_s cfg;
        logic [5:0]             ptr;
        logic [2:0]             sub;
        logic                   last_match;
        logic                   wr_valid;
        logic [5:0]             wr_addr;
        logic [7:0]             wr_data;
        logic                   wr_bank;
    } port_s;

    port_s st_q;
    port_s st_d;

    logic [5:0]              pins_sync;
    logic                    s_scl;
    logic                    s_sda;
    logic                    s_sel;
    logic [2:0]              hw_sub;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    start_cond;
    logic                    stop_cond;
    logic                    addr_hit;
    logic                    push_valid;
    logic                    push_ready;
    lcd_cmd_pkg::fifo_word_s push_word;
    logic                    pop_valid;
    logic                    pop_ready;
    lcd_cmd_pkg::fifo_word_s pop_word;
    logic                    drained;
    logic [6:0]              next_ptr;

    // Command format from bits 6..0
    function automatic lcd_cmd_pkg::cmd_e decode_cmd(input logic [6:0] b);
        lcd_cmd_pkg::cmd_e c;
        c = lcd_cmd_pkg::C_NONE;
        if (!b[6]) begin
            c = lcd_cmd_pkg::C_POINTER;
        end else if (!b[5]) begin
            c = lcd_cmd_pkg::C_MODE;
        end else if (b[4:3] == 2'h0) begin
            c = lcd_cmd_pkg::C_DEVSEL;
        end else if (b[4:3] == 2'h2) begin
            c = lcd_cmd_pkg::C_BLINK;
        end else if (b[4:2] == 3'h6) begin
            c = lcd_cmd_pkg::C_BANK;
        end
        return c;
    endfunction : decode_cmd

    // Bank switching exists only in static and two-way drive
    function automatic logic has_alt_bank(input logic [1:0] mode);
        return (mode == `DRIVE_STATIC) || (mode == `DRIVE_MUX2);
    endfunction : has_alt_bank

    // Pointer advance per data byte
    function automatic logic [6:0] ptr_step(input logic [1:0] mode);
        logic [6:0] s;
        case (mode)
            `DRIVE_STATIC: s = `STEP_STATIC;
            `DRIVE_MUX2:   s = `STEP_MUX2;
            `DRIVE_MUX3:   s = `STEP_MUX3;
            default:       s = `STEP_MUX4;
        endcase
        return s;
    endfunction : ptr_step

    // Bus lines and straps all come from outside the clock domain
    pin_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pin_i   ({hw_subaddr_bit_two_i, hw_subaddr_bit_one_i, hw_subaddr_bit_zero_i,
                   address_lsb_select_pin_i, sda_i, scl_i}),
        .sync_o  (pins_sync)
    );

    assign s_scl  = pins_sync[0];
    assign s_sda  = pins_sync[1];
    assign s_sel  = pins_sync[2];
    assign hw_sub = pins_sync[5:3];

    // Bus events from synchronised levels
    assign scl_rise   = s_scl && !st_q.scl_prev;
    assign scl_fall   = !s_scl && st_q.scl_prev;
    assign start_cond = s_scl && st_q.scl_prev && st_q.sda_prev && !s_sda;
    assign stop_cond  = s_scl && st_q.scl_prev && !st_q.sda_prev && s_sda;

    // Write address only; a read request is never answered
    assign addr_hit = (st_q.shreg[7:2] == `SLAVE_ADDR_UPPER)
                   && (st_q.shreg[1] == s_sel) && !st_q.shreg[0];

    // Each command or data byte is queued once
    assign push_valid = (st_q.lstate == lcd_cmd_pkg::L_HOLD)
                     && (st_q.kind != lcd_cmd_pkg::K_ADDR) && !st_q.pushed;
    assign push_word.is_cmd = (st_q.kind == lcd_cmd_pkg::K_CMD);
    assign push_word.data   = st_q.shreg;

    byte_fifo #(
        .WIDTH ($bits(lcd_cmd_pkg::fifo_word_s)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_word),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_word)
    );

    // Decoder takes a byte only when its previous work is done
    assign pop_ready = (st_q.busy_cnt == 5'h00);
    assign drained   = !pop_valid && (st_q.busy_cnt == 5'h00);
    assign next_ptr  = {1'b0, st_q.ptr} + ptr_step(st_q.cfg.drive_mode);

    // Link state and decoder, one next-state copy
    always_comb begin
        st_d          = st_q;
        st_d.scl_prev = s_scl;
        st_d.sda_prev = s_sda;
        st_d.wr_valid = 1'b0;

        // Receiver
        if (start_cond) begin
            st_d.lstate  = lcd_cmd_pkg::L_RECV;
            st_d.kind    = lcd_cmd_pkg::K_ADDR;
            st_d.bit_cnt = 4'h0;
            st_d.sda_oe  = 1'b0;
            st_d.scl_oe  = 1'b0;
        end else if (stop_cond) begin
            st_d.lstate = lcd_cmd_pkg::L_IDLE;
            st_d.sda_oe = 1'b0;
            st_d.scl_oe = 1'b0;
        end else begin
            case (st_q.lstate)
                lcd_cmd_pkg::L_RECV: begin
                    if (scl_rise) begin
                        st_d.shreg   = {st_q.shreg[6:0], s_sda};
                        st_d.bit_cnt = st_q.bit_cnt + 4'h1;
                        if (st_q.bit_cnt == 4'h7) begin
                            st_d.lstate = lcd_cmd_pkg::L_HOLD;
                            st_d.pushed = 1'b0;
                            st_d.fell   = 1'b0;
                        end
                    end
                end
                lcd_cmd_pkg::L_HOLD: begin
                    if (push_valid && push_ready) begin
                        st_d.pushed = 1'b1;
                    end
                    if (scl_fall) begin
                        st_d.fell = 1'b1;
                    end
                    if (st_q.fell) begin
                        st_d.ack_hi = 1'b0;
                        if (st_q.kind == lcd_cmd_pkg::K_ADDR) begin
                            if (addr_hit) begin
                                st_d.lstate = lcd_cmd_pkg::L_ACK;
                                st_d.sda_oe = 1'b1;
                                st_d.kind   = lcd_cmd_pkg::K_CMD;
                            end else begin
                                st_d.lstate = lcd_cmd_pkg::L_IGNORE;
                            end
                        end else if (st_q.pushed && (st_q.kind == lcd_cmd_pkg::K_CMD)) begin
                            st_d.lstate = lcd_cmd_pkg::L_ACK;
                            st_d.sda_oe = 1'b1;
                            if (!st_q.shreg[`CONT_BIT]) begin
                                st_d.kind = lcd_cmd_pkg::K_DATA;
                            end
                        end else if (st_q.pushed && drained) begin
                            // Data ack waits for the subaddress verdict
                            st_d.lstate = lcd_cmd_pkg::L_ACK;
                            st_d.sda_oe = st_q.last_match;
                        end else begin
                            st_d.scl_oe = 1'b1;
                        end
                    end
                end
                lcd_cmd_pkg::L_ACK: begin
                    // Clock freed a cycle after the ack so data leads the high phase
                    st_d.scl_oe = 1'b0;
                    if (scl_rise) begin
                        st_d.ack_hi = 1'b1;
                    end
                    if (st_q.ack_hi && scl_fall) begin
                        st_d.sda_oe  = 1'b0;
                        st_d.lstate  = lcd_cmd_pkg::L_RECV;
                        st_d.bit_cnt = 4'h0;
                    end
                end
                lcd_cmd_pkg::L_IGNORE: begin
                    st_d.sda_oe = 1'b0;
                end
                default: begin
                    st_d.lstate = lcd_cmd_pkg::L_IDLE;
                end
            endcase
        end

        // Decoder; in power-saving mode each byte costs a fixed busy time
        if (st_q.busy_cnt != 5'h00) begin
            st_d.busy_cnt = st_q.busy_cnt - 5'h01;
        end
        if (pop_valid && pop_ready) begin
            st_d.busy_cnt = st_q.cfg.power_saving ? LP_BUSY : 5'h00;
            if (pop_word.is_cmd) begin
                case (decode_cmd(pop_word.data[6:0]))
                    lcd_cmd_pkg::C_POINTER: begin
                        st_d.ptr = pop_word.data[5:0];
                    end
                    lcd_cmd_pkg::C_MODE: begin
                        st_d.cfg.power_saving = pop_word.data[`MODE_LP_BIT];
                        st_d.cfg.display_en   = pop_word.data[`MODE_EN_BIT];
                        st_d.cfg.bias_half    = pop_word.data[`MODE_BIAS_BIT];
                        st_d.cfg.drive_mode   = pop_word.data[1:0];
                    end
                    lcd_cmd_pkg::C_DEVSEL: begin
                        st_d.sub = pop_word.data[2:0];
                    end
                    lcd_cmd_pkg::C_BANK: begin
                        if (has_alt_bank(st_q.cfg.drive_mode)) begin
                            st_d.cfg.in_bank  = pop_word.data[`BANK_IN_BIT];
                            st_d.cfg.out_bank = pop_word.data[`BANK_OUT_BIT];
                        end
                    end
                    lcd_cmd_pkg::C_BLINK: begin
                        st_d.cfg.alt_blink  = pop_word.data[`BLINK_AB_BIT];
                        st_d.cfg.blink_rate = pop_word.data[1:0];
                    end
                    default: begin
                        st_d.cfg = st_q.cfg;
                    end
                endcase
            end else begin
                // Non-matching devices still advance to stay in step
                st_d.last_match = (st_q.sub == hw_sub);
                if (st_q.sub == hw_sub) begin
                    st_d.wr_valid = 1'b1;
                    st_d.wr_addr  = st_q.ptr;
                    st_d.wr_data  = pop_word.data;
                    st_d.wr_bank  = st_q.cfg.in_bank;
                end
                if (next_ptr > `PTR_LAST) begin
                    st_d.ptr = 6'(next_ptr - `PTR_SPAN);
                    st_d.sub = st_q.sub + 3'h1;
                end else begin
                    st_d.ptr = next_ptr[5:0];
                end
            end
        end
    end

    // Single state register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q                 <= '0;
            st_q.lstate          <= lcd_cmd_pkg::L_IDLE;
            st_q.kind            <= lcd_cmd_pkg::K_ADDR;
            st_q.scl_prev        <= 1'b1;
            st_q.sda_prev        <= 1'b1;
            st_q.cfg.drive_mode  <= `RST_DRIVE_MODE;
            st_q.cfg.blink_rate  <= `RST_BLINK_RATE;
            st_q.ptr             <= `RST_PTR;
            st_q.sub             <= `RST_SUBADDR;
        end else begin
            st_q <= st_d;
        end
    end

    // Open-drain lines only ever pull low
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = st_q.scl_oe;
    assign sda_oe_o = st_q.sda_oe;

    // Effective settings; bias and alternate blink gated by drive mode
    assign power_saving_select_o = st_q.cfg.power_saving;
    assign display_enable_o      = st_q.cfg.display_en;
    assign bias_half_o           = st_q.cfg.bias_half
                                && (st_q.cfg.drive_mode != `DRIVE_STATIC);
    assign drive_mode_o          = st_q.cfg.drive_mode;
    assign input_bank_o          = st_q.cfg.in_bank;
    assign output_bank_o         = st_q.cfg.out_bank;
    assign alt_bank_blink_flag_o = st_q.cfg.alt_blink
                                && has_alt_bank(st_q.cfg.drive_mode);
    assign blink_rate_field_o    = st_q.cfg.blink_rate;
    assign data_ptr_o            = st_q.ptr;
    assign subaddr_cnt_o         = st_q.sub;
    assign wr_valid_o            = st_q.wr_valid;
    assign wr_addr_o             = st_q.wr_addr;
    assign wr_data_o             = st_q.wr_data;
    assign wr_bank_o             = st_q.wr_bank;
endmodule : lcd_driver_i2c_command_port

/* File: lcd_cmd_defines.svh */
// Constants for the display driver serial command port
//
// Overview of operation
// - Acknowledge every command byte once addressed
// - Ack holds data low through ninth high
// - Receive only; outputs are ack and clock hold
// - Power-saving: hold clock low until data byte processed
// - Respond to address 011100 plus select pin
// - Other select level ignores transfer until stop or repeated start
// - All selected devices acknowledge command bytes
// - Bit 7 set means another command follows
// - Data stored, pointers advanced, ack on match
// - Hardware subaddress from three input pins
// - Decode five command formats from bits 6..0
// - Mode-set bit 4 selects power-saving
// - Mode-set bit 3 enables the display
// - Mode-set bit 2 bias, ignored when static
// - Mode-set bits 1..0 select drive mode
// - Load-pointer copies low six bits
// - Device-select copies low three bits
// - Bank-select only in static or two-way
// - Blink-select; alternate blink falls back when 3/4-way
`ifndef LCD_CMD_DEFINES_SVH
`define LCD_CMD_DEFINES_SVH

`define SLAVE_ADDR_UPPER 6'h1C
`define CONT_BIT         3'h7
`define MODE_LP_BIT      3'h4
`define MODE_EN_BIT      3'h3
`define MODE_BIAS_BIT    3'h2
`define BANK_IN_BIT      3'h1
`define BANK_OUT_BIT     3'h0
`define BLINK_AB_BIT     3'h2
`define PTR_LAST         7'h27
`define PTR_SPAN         7'h28
`define DRIVE_STATIC     2'h1
`define DRIVE_MUX2       2'h2
`define DRIVE_MUX3       2'h3
`define DRIVE_MUX4       2'h0
`define STEP_STATIC      7'h08
`define STEP_MUX2        7'h04
`define STEP_MUX3        7'h03
`define STEP_MUX4        7'h02
`define RST_DRIVE_MODE   2'h0
`define RST_BLINK_RATE   2'h0
`define RST_PTR          6'h00
`define RST_SUBADDR      3'h0
`define CLK_PERIOD_NS    50
`define LP_PROC_TIME_NS  800
`define LP_PROC_CYCLES   ((`LP_PROC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH       8

`endif

/* File: lcd_cmd_pkg.sv */
// Types shared by the display driver serial command port
package lcd_cmd_pkg;
    typedef enum logic [2:0] {
        L_IDLE, L_RECV, L_HOLD, L_ACK, L_IGNORE
    } link_e;

    typedef enum logic [1:0] {
        K_ADDR, K_CMD, K_DATA
    } kind_e;

    typedef enum logic [2:0] {
        C_POINTER, C_MODE, C_DEVSEL, C_BANK, C_BLINK, C_NONE
    } cmd_e;

    // One received byte with its command tag
    typedef struct packed {
        logic       is_cmd;
        logic [7:0] data;
    } fifo_word_s;

    // Settings left by the command stream
    typedef struct packed {
        logic       power_saving;
        logic       display_en;
        logic       bias_half;
        logic [1:0] drive_mode;
        logic       in_bank;
        logic       out_bank;
        logic       alt_blink;
        logic [1:0] blink_rate;
    } mode_cfg_s;
endpackage : lcd_cmd_pkg

/* File: pin_sync.sv */
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    // First stage feeds only the second
    always_comb begin
        st_d.meta   = pin_i;
        st_d.stable = st_q.meta;
    end

    // Idle bus level is high on every pin
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stable;
endmodule : pin_sync

/* File: byte_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
    } fifo_s;

    fifo_s st_q;
    fifo_s st_d;
    logic  full;
    logic  empty;

    // Extra pointer bit tells full from empty
    assign empty       = (st_q.wr_ptr == st_q.rd_ptr);
    assign full        = (st_q.wr_ptr[AW] != st_q.rd_ptr[AW])
                      && (st_q.wr_ptr[AW-1:0] == st_q.rd_ptr[AW-1:0]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = st_q.mem[st_q.rd_ptr[AW-1:0]];

    // Push and pop may share a cycle
    always_comb begin
        st_d = st_q;
        if (in_valid_i && !full) begin
            st_d.mem[st_q.wr_ptr[AW-1:0]] = in_data_i;
            st_d.wr_ptr = st_q.wr_ptr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            st_d.rd_ptr = st_q.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : byte_fifo

/* File: lcd_cmd_port_monitor.sv */
// Port checker for the display driver serial command port
`timescale 1ns/1ps
module lcd_cmd_port_monitor (
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic       scl_i,
    input wire logic       scl_o,
    input wire logic       scl_oe_o,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       power_saving_select_o,
    input wire logic       bias_half_o,
    input wire logic [1:0] drive_mode_o,
    input wire logic       input_bank_o,
    input wire logic       output_bank_o,
    input wire logic       alt_bank_blink_flag_o,
    input wire logic       wr_valid_o,
    input wire logic [5:0] wr_addr_o,
    input wire logic [7:0] wr_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Open-drain pins may only ever pull low
    chk_pins_pull_low: assert property (sda_o == 1'b0 && scl_o == 1'b0)
        else $error("pin data value not low");
    // Ack may not drop while the clock is still high
    chk_ack_held_high: assert property (sda_oe_o && scl_i |=> sda_oe_o)
        else $error("ack released during clock high");
    chk_store_one_pulse: assert property (wr_valid_o |=> !wr_valid_o)
        else $error("store strobe longer than one cycle");
    chk_store_data_held: assert property (!wr_valid_o |-> $stable(wr_addr_o) && $stable(wr_data_o))
        else $error("store address or data moved without strobe");
    chk_bias_static_off: assert property (drive_mode_o == 2'h1 |-> !bias_half_o)
        else $error("half bias reported in static mode");
    chk_alt_blink_fall: assert property (drive_mode_o inside {2'h0, 2'h3} |-> !alt_bank_blink_flag_o)
        else $error("alternate blink in three or four way");
    chk_bank_frozen_mux: assert property ($past(drive_mode_o) inside {2'h0, 2'h3}
        && drive_mode_o inside {2'h0, 2'h3} |-> $stable({input_bank_o, output_bank_o}))
        else $error("bank changed in three or four way");
    // Normal power only allows a short hold of the clock
    chk_stretch_normal: assert property (scl_oe_o && !power_saving_select_o |-> ##[0:6] !scl_oe_o)
        else $error("clock held too long in normal power");
    chk_stretch_to_ack: assert property ($fell(scl_oe_o) |-> sda_oe_o)
        else $error("clock released without ack");
    cov_store: cover property (wr_valid_o);
    cov_stretch_lp: cover property (scl_oe_o && power_saving_select_o);
    cov_ack: cover property ($rose(sda_oe_o));
endmodule : lcd_cmd_port_monitor

bind lcd_driver_i2c_command_port lcd_cmd_port_monitor i_mon (.clk_i, .rst_b_i, .scl_i, .scl_o,
    .scl_oe_o, .sda_o, .sda_oe_o, .power_saving_select_o, .bias_half_o, .drive_mode_o,
    .input_bank_o, .output_bank_o, .alt_bank_blink_flag_o, .wr_valid_o, .wr_addr_o, .wr_data_o);

/* File: i2c_master_model.sv */
// Behavioural serial bus master that writes bytes to the port
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_drv_o,
    output logic      sda_drv_o
);
    localparam int HALF = 10;
    int stuck = 0;
    initial begin
        scl_drv_o = 1'b0;
        sda_drv_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // Data moves only mid low phase, sampled mid high phase
    task automatic put_bit(input logic b, output logic r);
        int w;
        w = 0;
        tick(HALF / 2);
        sda_drv_o <= !b;
        tick(HALF / 2);
        scl_drv_o <= 1'b0;
        tick(1);
        // Device may hold the clock low; wait with a bound
        while (scl_i !== 1'b1 && w < 400) begin
            w++;
            tick(1);
        end
        if (w >= 400) stuck++;
        tick(HALF / 2);
        r = sda_i;
        tick(HALF / 2);
        scl_drv_o <= 1'b1;
    endtask : put_bit
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(v[i], r);
        put_bit(1'b1, r);
        ack = !r;
    endtask : put_byte
    // Works from idle and as a repeated start
    task automatic start();
        tick(HALF / 2);
        sda_drv_o <= 1'b0;
        scl_drv_o <= 1'b0;
        tick(HALF);
        sda_drv_o <= 1'b1;
        tick(HALF / 2);
        scl_drv_o <= 1'b1;
    endtask : start
    task automatic stop();
        tick(HALF / 2);
        sda_drv_o <= 1'b1;
        tick(HALF / 2);
        scl_drv_o <= 1'b0;
        tick(HALF / 2);
        sda_drv_o <= 1'b0;
        tick(HALF);
    endtask : stop
endmodule : i2c_master_model

/* File: lcd_driver_i2c_command_port_tb_top.sv */
// Testbench for the display driver serial command port
`timescale 1ns/1ps
module lcd_driver_i2c_command_port_tb_top;
    typedef struct packed { logic [5:0] a; logic [7:0] d; logic b; } wr_s;
    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       address_lsb_select_pin_i = 1'b0;
    logic [2:0] hw = 3'h0;
    logic       scl_drv, sda_drv, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic       power_saving_select_o, display_enable_o, bias_half_o;
    logic       input_bank_o, output_bank_o, alt_bank_blink_flag_o;
    logic [1:0] drive_mode_o, blink_rate_field_o;
    logic [5:0] data_ptr_o, wr_addr_o;
    logic [2:0] subaddr_cnt_o;
    logic       wr_valid_o, wr_bank_o;
    logic [7:0] wr_data_o, d;
    wire logic  scl_i = !(scl_drv | scl_oe_o);
    wire logic  sda_i = !(sda_drv | sda_oe_o);
    wire logic  hw_subaddr_bit_zero_i = hw[0];
    wire logic  hw_subaddr_bit_one_i = hw[1];
    wire logic  hw_subaddr_bit_two_i = hw[2];
    wire logic [9:0] cfg = {power_saving_select_o, display_enable_o, bias_half_o, drive_mode_o,
        input_bank_o, output_bank_o, alt_bank_blink_flag_o, blink_rate_field_o};
    int   n_fail = 0;
    int   tests_run = 0;
    int   cycles = 0;
    int   seed = 11371;
    wr_s  exp_q[$];
    logic sel;
    always #25 clk_i = !clk_i;
    lcd_driver_i2c_command_port i_dut (.*);
    i2c_master_model i_mst (.clk_i, .scl_i, .sda_i, .scl_drv_o(scl_drv), .sda_drv_o(sda_drv));
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %0h seen %0h", nm, e, g);
            n_fail++;
        end
    endtask : check
    task automatic send(input logic [7:0] v, input logic ea);
        logic a;
        i_mst.put_byte(v, a);
        check("ack", ea, a);
    endtask : send
    task automatic give_verdict();
        n_fail += i_mst.stuck;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // Stores are matched against the oldest expected note
    always @(posedge clk_i) begin
        if (wr_valid_o === 1'b1) begin
            if (exp_q.size() == 0) check("wr_unexpected", 16'h0, 16'h1);
            else check("wr", exp_q.pop_front(), {wr_addr_o, wr_data_o, wr_bank_o});
        end
    end
    // Hang guard well above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        @(posedge clk_i);
        hw <= 3'($random(seed));
        address_lsb_select_pin_i <= 1'($random(seed));
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        sel = address_lsb_select_pin_i;
        check("cfg", 16'h0, cfg);
        check("ptr_sub", 16'h0, {data_ptr_o, subaddr_cnt_o});
        $display("test reset done");
        // Other select level and read direction are ignored
        i_mst.start();
        send({6'h1C, !sel, 1'b0}, 1'b0);
        send(8'hCE, 1'b0);
        i_mst.stop();
        i_mst.start();
        send({6'h1C, sel, 1'b1}, 1'b0);
        i_mst.stop();
        check("cfg", 16'h0, cfg);
        $display("test refuse done");
        // Command chain, then data across the pointer wrap
        i_mst.start();
        send({6'h1C, sel, 1'b0}, 1'b1);
        send(8'hCE, 1'b1);
        send(8'hFB, 1'b1);
        send(8'hF5, 1'b1);
        send(8'hE0 | hw, 1'b1);
        send(8'h26, 1'b1);
        d = 8'($random(seed));
        exp_q.push_back({6'h26, d, 1'b1});
        send(d, 1'b1);
        send(8'($random(seed)), 1'b0);
        i_mst.stop();
        check("cfg", 16'h1DD, cfg);
        check("ptr_sub", {6'h06, hw + 3'h1}, {data_ptr_o, subaddr_cnt_o});
        $display("test chain done");
        // Power-saving static mode with stretched data acks
        i_mst.start();
        send({6'h1C, sel, 1'b0}, 1'b1);
        send(8'hE0 | hw, 1'b1);
        send(8'h80, 1'b1);
        send(8'h5D, 1'b1);
        for (int i = 0; i < 2; i++) begin
            d = 8'($random(seed));
            exp_q.push_back({6'(8 * i), d, 1'b1});
            send(d, 1'b1);
        end
        check("cfg", 16'h33D, cfg);
        // Repeated start returns to command decoding
        i_mst.start();
        send({6'h1C, sel, 1'b0}, 1'b1);
        send(8'hCB, 1'b1);
        send(8'hF8, 1'b1);
        send(8'h74, 1'b1);
        i_mst.stop();
        repeat (40) @(posedge clk_i);
        check("cfg", 16'h178, cfg);
        check("pending", 16'h0, 16'(exp_q.size()));
        $display("test power saving done");
        give_verdict();
    end
endmodule : lcd_driver_i2c_command_port_tb_top
